// ===== ccr_regs.sv
// Channel 1 configuration register bank with AXI4-Lite slave and enable decode.
// Functional notes
// - Output voltage is 0.5V plus 25mV per code.
// - Discharge bit clear: no discharge when disabled.
// - Discharge bit set: resistor on when disabled.
// - Selector 0-3 follows matching sequencer slot.
`timescale 1ns/1ps
module ccr_regs
	import ccr_pkg::*;
(
	input  wire logic                           ref_clk_i,
	input  wire logic                           sys_rst_i,
	input  wire logic [ccr_pkg::ADDR_W-1:0]     s_axi_awaddr_i,
	input  wire logic                           s_axi_awvalid_i,
	output logic                                s_axi_awready_o,
	input  wire logic [ccr_pkg::DATA_W-1:0]     s_axi_wdata_i,
	input  wire logic [ccr_pkg::DATA_W/8-1:0]   s_axi_wstrb_i,
	input  wire logic                           s_axi_wvalid_i,
	output logic                                s_axi_wready_o,
	output logic [1:0]                          s_axi_bresp_o,
	output logic                                s_axi_bvalid_o,
	input  wire logic                           s_axi_bready_i,
	input  wire logic [ccr_pkg::ADDR_W-1:0]     s_axi_araddr_i,
	input  wire logic                           s_axi_arvalid_i,
	output logic                                s_axi_arready_o,
	output logic [ccr_pkg::DATA_W-1:0]          s_axi_rdata_o,
	output logic [1:0]                          s_axi_rresp_o,
	output logic                                s_axi_rvalid_o,
	input  wire logic                           s_axi_rready_i,
	input  wire logic [ccr_pkg::SLOT_COUNT-1:0] seq_slot_on_i,
	output logic [ccr_pkg::REG_W-1:0]           ch1_target_code_o,
	output logic [11:0]                         ch1_target_mv_o,
	output logic                                ch1_target_bad_o,
	output logic                                ch1_on_o,
	output logic                                ch1_discharge_o
);
	import ccr_pkg::*;

	logic [REG_W-1:0]      target_reg;
	logic [REG_W-1:0]      endis_reg;
	logic [ADDR_W-1:0]     awaddr_reg;
	logic                  aw_held_reg;
	logic [DATA_W-1:0]     wdata_reg;
	logic                  wstrb0_reg;
	logic                  w_held_reg;
	logic [SLOT_COUNT-1:0] slot_meta_reg;
	logic [SLOT_COUNT-1:0] slot_sync_reg;
	logic                  wr_fire;
	logic                  wr_hit;
	ccr_mode_t             mode_unused;

	// Address and data may arrive in either order; each is held until both are present.
	assign s_axi_awready_o = !aw_held_reg && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_held_reg && !s_axi_bvalid_o;
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign wr_fire         = aw_held_reg && w_held_reg && !s_axi_bvalid_o;
	assign wr_hit          = (awaddr_reg == TARGET_ADDR) || (awaddr_reg == ENDIS_ADDR);

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aw_held_reg <= 1'b0;
			awaddr_reg  <= '0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held_reg <= 1'b1;
			awaddr_reg  <= s_axi_awaddr_i;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			w_held_reg <= 1'b0;
			wdata_reg  <= '0;
			wstrb0_reg <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held_reg <= 1'b1;
			wdata_reg  <= s_axi_wdata_i;
			wstrb0_reg <= s_axi_wstrb_i[0];
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end
	end

	// Only byte lane 0 carries register bits; upper lanes are ignored.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			target_reg <= TARGET_RESET;
			endis_reg  <= ENDIS_RESET;
		end else if (wr_fire && wstrb0_reg) begin
			if (awaddr_reg == TARGET_ADDR) begin
				target_reg <= wdata_reg[REG_W-1:0];
			end
			if (awaddr_reg == ENDIS_ADDR) begin
				endis_reg <= wdata_reg[REG_W-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= '0;
			s_axi_rresp_o  <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			case (s_axi_araddr_i)
				TARGET_ADDR: begin
					s_axi_rdata_o <= {{(DATA_W-REG_W){1'b0}}, target_reg};
					s_axi_rresp_o <= RESP_OKAY;
				end
				ENDIS_ADDR: begin
					s_axi_rdata_o <= {{(DATA_W-REG_W){1'b0}}, endis_reg};
					s_axi_rresp_o <= RESP_OKAY;
				end
				default: begin
					s_axi_rdata_o <= '0;
					s_axi_rresp_o <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// Sequencer slot levels come from another block's timing, so they are synchronised.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			slot_meta_reg <= '0;
			slot_sync_reg <= '0;
		end else begin
			slot_meta_reg <= seq_slot_on_i;
			slot_sync_reg <= slot_meta_reg;
		end
	end

	// Millivolt figure is exported for monitoring; codes above the maximum are flagged, not clipped.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ch1_target_code_o <= TARGET_RESET;
			ch1_target_mv_o   <= 12'(BASE_MV);
			ch1_target_bad_o  <= 1'b0;
		end else begin
			ch1_target_code_o <= target_reg;
			ch1_target_mv_o   <= 12'(BASE_MV) + 12'(STEP_MV) * {4'h0, target_reg};
			ch1_target_bad_o  <= target_reg > TARGET_MAX_CODE;
		end
	end

	ccr_decode u_decode (
		.ref_clk_i      (ref_clk_i),
		.sys_rst_i      (sys_rst_i),
		.enable_sel_i   (endis_reg[SEL_MSB:SEL_LSB]),
		.discharge_en_i (endis_reg[DISCH_BIT]),
		.slot_on_i      (slot_sync_reg),
		.ch_on_o        (ch1_on_o),
		.discharge_o    (ch1_discharge_o),
		.mode_o         (mode_unused)
	);

	a_bresp_after_both: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		wr_fire |=> s_axi_bvalid_o) else $error("Write response missing.");
	a_bvalid_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("Response dropped.");
	a_mv_linear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		##1 ch1_target_mv_o == 12'(BASE_MV) + 12'(STEP_MV) * {4'h0, $past(target_reg)})
		else $error("Voltage figure not linear in code.");
	a_rsvd_readback: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		wr_fire && wstrb0_reg && awaddr_reg == ENDIS_ADDR |=> endis_reg == wdata_reg[7:0])
		else $error("Enable register did not store all bits.");
	a_reset_clear: assert property (@(posedge ref_clk_i)
		$fell(sys_rst_i) |-> target_reg == 8'h00 && endis_reg == 8'h00)
		else $error("Registers not clear after reset.");
	a_mode_on_drives: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		mode_unused == CCR_MODE_ON |-> ch1_on_o) else $error("Forced on mode left channel off.");
	a_bad_flag: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		target_reg == 8'h8D |=> ch1_target_bad_o) else $error("Reserved code not flagged.");
endmodule // ccr_regs

// ===== ccr_pkg.sv
// Package with register map, field layout and reset values for the channel 1 config bank.
package ccr_pkg;
	localparam int unsigned ADDR_W          = 8;
	localparam int unsigned DATA_W          = 32;
	localparam int unsigned REG_W           = 8;
	localparam int unsigned SLOT_COUNT      = 4;
	// Printed offsets are not multiples of four, so they are indices and byte address is 4x.
	localparam logic [7:0]  TARGET_IDX      = 8'h0A;
	localparam logic [7:0]  ENDIS_IDX       = 8'h0B;
	localparam logic [7:0]  TARGET_ADDR     = 8'h28;
	localparam logic [7:0]  ENDIS_ADDR      = 8'h2C;
	localparam logic [7:0]  TARGET_RESET    = 8'h00;
	localparam logic [7:0]  ENDIS_RESET     = 8'h00;
	localparam int unsigned DISCH_BIT       = 3;
	localparam int unsigned SEL_MSB         = 2;
	localparam int unsigned SEL_LSB         = 0;
	localparam logic [2:0]  SEL_OFF_A       = 3'h4;
	localparam logic [2:0]  SEL_OFF_B       = 3'h5;
	localparam logic [2:0]  SEL_ON_A        = 3'h6;
	localparam logic [2:0]  SEL_ON_B        = 3'h7;
	localparam logic [7:0]  TARGET_MAX_CODE = 8'h8C;
	localparam int unsigned BASE_MV         = 500;
	localparam int unsigned STEP_MV         = 25;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	typedef enum logic [1:0] {CCR_MODE_SLOT, CCR_MODE_OFF, CCR_MODE_ON} ccr_mode_t;
endpackage

// ===== ccr_decode.sv
// Decoder from enable selector and sequencer slot states to channel enable and discharge.
`timescale 1ns/1ps
module ccr_decode
	import ccr_pkg::*;
(
	input  wire logic                    ref_clk_i,
	input  wire logic                    sys_rst_i,
	input  wire logic [2:0]              enable_sel_i,
	input  wire logic                    discharge_en_i,
	input  wire logic [ccr_pkg::SLOT_COUNT-1:0] slot_on_i,
	output logic                         ch_on_o,
	output logic                         discharge_o,
	output ccr_pkg::ccr_mode_t           mode_o
);
	import ccr_pkg::*;

	ccr_mode_t mode_next;
	logic      on_next;

	always_comb begin
		mode_next = CCR_MODE_SLOT;
		on_next   = 1'b0;
		case (enable_sel_i)
			SEL_OFF_A, SEL_OFF_B: begin
				mode_next = CCR_MODE_OFF;
				on_next   = 1'b0;
			end
			SEL_ON_A, SEL_ON_B: begin
				mode_next = CCR_MODE_ON;
				on_next   = 1'b1;
			end
			default: begin
				mode_next = CCR_MODE_SLOT;
				on_next   = slot_on_i[enable_sel_i[1:0]];
			end
		endcase
	end

	// Outputs are registered so the analog controls never see decode glitches.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ch_on_o     <= 1'b0;
			discharge_o <= 1'b0;
			mode_o      <= CCR_MODE_SLOT;
		end else begin
			ch_on_o     <= on_next;
			discharge_o <= discharge_en_i & ~on_next;
			mode_o      <= mode_next;
		end
	end

	a_disch_off_when_on: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		ch_on_o |-> !discharge_o) else $error("Discharge active while channel on.");
	a_disch_needs_en: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!$past(discharge_en_i) |-> !discharge_o) else $error("Discharge without enable.");
	a_force_off_sel: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(enable_sel_i == SEL_OFF_A || enable_sel_i == SEL_OFF_B) |=> !ch_on_o)
		else $error("Forced off selector left channel on.");
	a_force_on_sel: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		enable_sel_i[2:1] == 2'h3 |=> ch_on_o) else $error("Forced on selector failed.");
	a_slot_follow: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!enable_sel_i[2] |=> ch_on_o == $past(slot_on_i[enable_sel_i[1:0]]))
		else $error("Channel does not follow its slot.");
endmodule // ccr_decode

// ===== ccr_regs_test.sv
// Self-checking testbench for the channel 1 configuration register bank.
`timescale 1ns/1ps
module ccr_regs_test;
	import ccr_pkg::*;
	logic        ref_clk_i;
	logic        sys_rst_i;
	logic [7:0]  awaddr;
	logic [7:0]  araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0]  wstrb;
	logic [3:0]  slot_on;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic [7:0]  code;
	logic [11:0] mv;
	logic        bad, on, dis, exp_on;
	logic [7:0]  codes [6] = '{8'h00, 8'h01, 8'h8B, 8'h8C, 8'h8D, 8'hFF};
	int          n_errors, n_checks, cycles;

	ccr_regs i_dut (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .seq_slot_on_i(slot_on),
		.ch1_target_code_o(code), .ch1_target_mv_o(mv), .ch1_target_bad_o(bad),
		.ch1_on_o(on), .ch1_discharge_o(dis)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// The ceiling sits far above the few hundred cycles the tests need, so only a hang hits it.
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR at %0t: seen 0x%08h expected 0x%08h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	task automatic do_reset();
		sys_rst_i <= 1'b1;
		tick(6);
		sys_rst_i <= 1'b0;
		tick(1);
	endtask

	// Address and data are offered together and each is released on the edge that takes it.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge ref_clk_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		check(32'(bresp), 32'(er));
	endtask

	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge ref_clk_i);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		check(rdata, ed);
		check(32'(rresp), 32'(er));
	endtask

	initial begin
		{awaddr, araddr, wdata, slot_on, awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
		sys_rst_i = 1'b1;
		n_errors = 0;
		n_checks = 0;
		cycles = 0;
		do_reset();
		check(32'(mv), 32'd500);
		check({code, bad, on, dis}, 0);
		axi_read(TARGET_ADDR, 0, RESP_OKAY);
		axi_read(ENDIS_ADDR, 0, RESP_OKAY);
		$display("Test reset values done");
		foreach (codes[i]) begin
			axi_write(TARGET_ADDR, 32'(codes[i]), 4'hF, RESP_OKAY);
			axi_read(TARGET_ADDR, 32'(codes[i]), RESP_OKAY);
			tick(2);
			check(32'(code), 32'(codes[i]));
			if (codes[i] <= 8'h8C) check(32'(mv), 500 + 25 * codes[i]);
			check(32'(bad), 32'(codes[i] > 8'h8C));
		end
		$display("Test target codes done");
		// Each selector is tried with both discharge settings and both slot patterns.
		for (int s = 0; s < 8; s++) begin
			for (int d = 0; d < 2; d++) begin
				slot_on <= 4'h5;
				axi_write(ENDIS_ADDR, 32'(d * 8 + s), 4'hF, RESP_OKAY);
				for (int k = 0; k < 2; k++) begin
					tick(4);
					exp_on = (s < 4) ? slot_on[s] : (s >= 6);
					check(32'(on), 32'(exp_on));
					check(32'(dis), 32'(d == 1 && !exp_on));
					slot_on <= 4'hA;
				end
			end
		end
		$display("Test selector and discharge done");
		axi_write(ENDIS_ADDR, 32'hF6, 4'hF, RESP_OKAY);
		axi_read(ENDIS_ADDR, 32'hF6, RESP_OKAY);
		tick(4);
		// Bias low power is set elsewhere once the channel is on; here the channel only has to be on.
		check({on, dis}, 2'b10);
		axi_write(ENDIS_ADDR, 32'h9C, 4'hF, RESP_OKAY);
		axi_read(ENDIS_ADDR, 32'h9C, RESP_OKAY);
		tick(4);
		check({on, dis}, 2'b01);
		$display("Test reserved bits done");
		axi_write(TARGET_ADDR, 32'h33, 4'h0, RESP_OKAY);
		axi_read(TARGET_ADDR, 32'hFF, RESP_OKAY);
		axi_write(8'h30, 32'h77, 4'hF, RESP_SLVERR);
		axi_read(8'h30, 0, RESP_SLVERR);
		$display("Test strobe and unmapped done");
		do_reset();
		axi_read(TARGET_ADDR, 0, RESP_OKAY);
		axi_read(ENDIS_ADDR, 0, RESP_OKAY);
		check({code, on, dis}, 0);
		$display("Test second reset done");
		print_verdict();
	end
endmodule // ccr_regs_test
